// ===== rtl/dfc_cmd_seq.sv
// command decoder and embedded algorithm control for both flash arrays
//
// Summary of operation
// - main array: sixteen 64K sectors, own selects
// - boot array: four sectors 16/8/8/32K, selects
// - protected sectors refuse program and erase
// - erase whole sectors, program one word
// - B0h suspends sector erase, 30h resumes
// - busy pin low during program or erase
// - select inputs may merge several decode terms
// - plain reads return data, plain writes ignored
// - commands only from ordered write sequences
// - AA/55/90 unlock, read XX02h gives ID
// - after 90h, XX04h reads protection 00h/01h
// - AA/55/A0 then data word at target
// - sector erase AA55 80 AA55 30h, more 30h
// - AA55 80 AA55 then 10h bulk erase
// - ID mode left only by F0h; status mode ends with the operation or B0h
// - bypass: 20h entry, A0h+data, 90h 00h exit
// - command addresses compare A11 to A0 only
`timescale 1ns/1ps
`default_nettype none
module dfc_cmd_seq
  import dfc_pkg::*;
#(
  parameter int ERASE_TIME_CYCLES = ERASE_CYCLES,
  parameter logic [15:0] FLASH_ID = FLASH_ID_DEFAULT // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic [DATA_W-1:0] array_rdata,
  input wire logic [NUM_MAIN-1:0] main_sector_select,
  input wire logic [NUM_BOOT-1:0] boot_sector_select,
  input wire logic [NUM_MAIN-1:0] main_protect,
  input wire logic [NUM_BOOT-1:0] boot_protect,
  output logic [DATA_W-1:0] bus_rdata,
  output logic busy_status_pin,
  output logic prog_strobe,
  output logic [ADDR_W-1:0] program_target_address,
  output logic [DATA_W-1:0] program_word_value,
  output logic erase_strobe,
  output logic [NUM_MAIN-1:0] erase_main_mask,
  output logic [NUM_BOOT-1:0] erase_boot_mask,
  output logic erase_suspended
);
  typedef enum logic [3:0] {
    ST_READ = 4'h0,
    ST_UNLK1 = 4'h1,
    ST_UNLK2 = 4'h2,
    ST_PROG_WAIT = 4'h3,
    ST_ERS1 = 4'h4,
    ST_ERS2 = 4'h5,
    ST_ERS3 = 4'h6,
    ST_ID = 4'h7,
    ST_BYP = 4'h8,
    ST_BYP_EXIT = 4'h9,
    ST_PROG_RUN = 4'hA,
    ST_ERS_COLLECT = 4'hB,
    ST_ERASING = 4'hC,
    ST_SUSPEND = 4'hD
  } dfc_state_e;

  dfc_state_e state, next_state;
  logic bypass, next_bypass;
  logic toggle, next_toggle;
  logic [10:0] window, next_window;
  logic [DATA_W-1:0] next_rdata;
  logic next_prog_strobe, next_erase_strobe;
  logic [ADDR_W-1:0] next_target;
  logic [DATA_W-1:0] next_word;
  logic [NUM_MAIN-1:0] next_main_mask;
  logic [NUM_BOOT-1:0] next_boot_mask;
  logic timer_start, timer_running, timer_done;
  logic [TIMER_W-1:0] timer_load;

  logic [7:0] cmd;
  logic [11:0] cmd_addr;
  logic at_a, at_b, sel_any, sel_prot;

  assign cmd = bus_wdata[7:0];
  assign cmd_addr = bus_addr[CMD_ADDR_W-1:0];
  assign at_a = (cmd_addr == UNLOCK_ADDR_A);
  assign at_b = (cmd_addr == UNLOCK_ADDR_B);
  // selects arrive already decoded, any product term mix allowed
  assign sel_any = (|main_sector_select) | (|boot_sector_select);
  assign sel_prot = (|(main_sector_select & main_protect))
                  | (|(boot_sector_select & boot_protect));

  dfc_op_timer #(.W(TIMER_W)) u_timer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .start(timer_start),
    .load(timer_load),
    // pause on the suspend edge itself, so done cannot fire while suspended
    .pause(next_state == ST_SUSPEND),
    .running(timer_running),
    .done(timer_done)
  );

  always_comb begin
    next_state = state;
    next_bypass = bypass;
    next_toggle = toggle;
    next_window = window;
    next_prog_strobe = 1'b0;
    next_erase_strobe = 1'b0;
    next_target = program_target_address;
    next_word = program_word_value;
    next_main_mask = erase_main_mask;
    next_boot_mask = erase_boot_mask;
    timer_start = 1'b0;
    timer_load = TIMER_W'(PROG_CYCLES);
    next_rdata = array_rdata;
    case (state)
      ST_READ: begin
        if (bus_wr && cmd == CMD_UNLOCK1 && at_a) begin
          next_state = ST_UNLK1;
        end
      end
      ST_UNLK1: begin
        if (bus_wr) begin
          next_state = (cmd == CMD_UNLOCK2 && at_b) ? ST_UNLK2 : ST_READ;
        end
      end
      ST_UNLK2: begin
        if (bus_wr) begin
          next_state = ST_READ;
          if (at_a && cmd == CMD_ID) next_state = ST_ID;
          if (at_a && cmd == CMD_PROGRAM) next_state = ST_PROG_WAIT;
          if (at_a && cmd == CMD_ERASE_SETUP) next_state = ST_ERS1;
          if (at_a && cmd == CMD_BYPASS) begin
            next_state = ST_BYP;
            next_bypass = 1'b1;
          end
        end
      end
      ST_PROG_WAIT: begin
        if (bus_wr) begin
          // one word per program command; protected target falls back
          if (sel_any && !sel_prot) begin
            next_state = ST_PROG_RUN;
            next_prog_strobe = 1'b1;
            next_target = bus_addr;
            next_word = bus_wdata;
            timer_start = 1'b1;
          end else begin
            next_state = bypass ? ST_BYP : ST_READ;
          end
        end
      end
      ST_ERS1: begin
        if (bus_wr) begin
          next_state = (cmd == CMD_UNLOCK1 && at_a) ? ST_ERS2 : ST_READ;
        end
      end
      ST_ERS2: begin
        if (bus_wr) begin
          next_state = (cmd == CMD_UNLOCK2 && at_b) ? ST_ERS3 : ST_READ;
        end
      end
      ST_ERS3: begin
        if (bus_wr) begin
          next_state = ST_READ;
          if (cmd == CMD_SECTOR_ERASE && sel_any && !sel_prot) begin
            next_state = ST_ERS_COLLECT;
            next_main_mask = main_sector_select;
            next_boot_mask = boot_sector_select;
            next_window = 11'(ADD_WINDOW_CYCLES);
          end
          if (cmd == CMD_BULK_ERASE && at_a && sel_any) begin
            next_main_mask = (|main_sector_select) ? ~main_protect : '0;
            next_boot_mask = (|boot_sector_select) ? ~boot_protect : '0;
            next_state = ST_ERS_COLLECT;
            next_window = 11'd1;
          end
        end
      end
      ST_ERS_COLLECT: begin
        // 80 us after each 30h before the erase starts
        if (bus_wr && cmd == CMD_SECTOR_ERASE) begin
          if (sel_any && !sel_prot) begin
            next_main_mask = erase_main_mask | main_sector_select;
            next_boot_mask = erase_boot_mask | boot_sector_select;
          end
          next_window = 11'(ADD_WINDOW_CYCLES);
        end else if (bus_wr) begin
          next_state = ST_READ;
          next_main_mask = '0;
          next_boot_mask = '0;
        end else if (window == 11'd1) begin
          next_state = ST_ERASING;
          next_erase_strobe = 1'b1;
          timer_start = 1'b1;
          timer_load = TIMER_W'(ERASE_TIME_CYCLES);
        end else begin
          next_window = window - 11'd1;
        end
      end
      ST_PROG_RUN, ST_ERASING: begin
        if (bus_rd) begin
          // status word: bit 7 polls data, bit 6 toggles per read
          next_rdata = {8'h00, (state == ST_PROG_RUN) ? ~program_word_value[7] : 1'b0,
                        toggle, 6'h00};
          next_toggle = ~toggle;
        end
        // a finished erase wins over a late suspend, else resume would hang
        if (timer_done) begin
          next_state = (state == ST_PROG_RUN && bypass) ? ST_BYP : ST_READ;
          if (state == ST_ERASING) begin
            next_main_mask = '0;
            next_boot_mask = '0;
          end
        end else if (state == ST_ERASING && bus_wr && cmd == CMD_SUSPEND) begin
          next_state = ST_SUSPEND;
        end
      end
      ST_SUSPEND: begin
        if (bus_wr && cmd == CMD_RESUME) next_state = ST_ERASING;
      end
      ST_ID: begin
        if (bus_rd && bus_addr[7:0] == ID_READ_OFS) next_rdata = FLASH_ID;
        if (bus_rd && bus_addr[7:0] == PROT_READ_OFS) begin
          next_rdata = {15'h0000, sel_prot};
        end
        if (bus_wr && cmd == CMD_RESET) next_state = ST_READ;
      end
      ST_BYP: begin
        if (bus_wr && cmd == CMD_PROGRAM) next_state = ST_PROG_WAIT;
        if (bus_wr && cmd == CMD_ID) next_state = ST_BYP_EXIT;
      end
      ST_BYP_EXIT: begin
        if (bus_wr) begin
          next_state = (cmd == CMD_BYPASS_EXIT) ? ST_READ : ST_BYP;
          next_bypass = (cmd != CMD_BYPASS_EXIT);
        end
      end
      default: begin
        next_state = ST_READ;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_READ;
      bypass <= 1'b0;
      toggle <= 1'b0;
      window <= 11'd0;
      bus_rdata <= 16'h0000;
      busy_status_pin <= 1'b1;
      prog_strobe <= 1'b0;
      erase_strobe <= 1'b0;
      program_target_address <= 16'h0000;
      program_word_value <= 16'h0000;
      erase_main_mask <= 16'h0000;
      erase_boot_mask <= 4'h0;
      erase_suspended <= 1'b0;
    end else begin
      state <= next_state;
      bypass <= next_bypass;
      toggle <= next_toggle;
      window <= next_window;
      bus_rdata <= next_rdata;
      // suspended erase counts as ready so other sectors can be read
      busy_status_pin <= !(next_state == ST_PROG_RUN || next_state == ST_ERASING
                           || next_state == ST_ERS_COLLECT);
      prog_strobe <= next_prog_strobe;
      erase_strobe <= next_erase_strobe;
      program_target_address <= next_target;
      program_word_value <= next_word;
      erase_main_mask <= next_main_mask;
      erase_boot_mask <= next_boot_mask;
      erase_suspended <= (next_state == ST_SUSPEND);
    end
  end

  AST_BUSY_PROG: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == ST_PROG_RUN) |-> !busy_status_pin) else $error("busy pin high during program");
  AST_READY_IDLE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == ST_READ && $past(state) == ST_READ) |-> busy_status_pin)
    else $error("busy pin low while idle");
  AST_PLAIN_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == ST_READ && bus_wr) |=> !prog_strobe && !erase_strobe)
    else $error("plain write reached the array");
  AST_PROT_REFUSE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == ST_PROG_WAIT && bus_wr && sel_prot) |=> !prog_strobe ##1 !prog_strobe)
    else $error("program of protected sector");
  AST_PROG_WORD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == ST_PROG_WAIT && bus_wr && sel_any && !sel_prot)
    |=> prog_strobe && program_word_value == $past(bus_wdata) && !busy_status_pin)
    else $error("program word not launched");
  AST_ID_READ: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == ST_ID && bus_rd && bus_addr[7:0] == ID_READ_OFS) |=> bus_rdata == FLASH_ID)
    else $error("wrong flash id");
  AST_PROT_READ: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == ST_ID && bus_rd && bus_addr[7:0] == PROT_READ_OFS)
    |=> bus_rdata == {15'h0000, $past(sel_prot)}) else $error("wrong protection status");
  AST_SUSPEND: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == ST_ERASING && bus_wr && cmd == CMD_SUSPEND && !timer_done)
    |=> erase_suspended && busy_status_pin) else $error("suspend not taken");
  AST_RESUME: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == ST_SUSPEND && bus_wr && cmd == CMD_RESUME)
    |=> !erase_suspended && !busy_status_pin) else $error("resume not taken");
  AST_ID_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == ST_ID && bus_wr && cmd != CMD_RESET) |=> state == ST_ID)
    else $error("left id mode without reset command");
  AST_BREAK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == ST_UNLK1 && bus_wr && !(cmd == CMD_UNLOCK2 && at_b)) |=> state == ST_READ)
    else $error("broken sequence kept");
  AST_ERASE_START: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == ST_ERS_COLLECT && !bus_wr && window == 11'd1) |=> erase_strobe ##1 !erase_strobe)
    else $error("erase did not start after window");
endmodule : dfc_cmd_seq
`default_nettype wire

// ===== rtl/dfc_op_timer.sv
// down counter timing one embedded program or erase step
`timescale 1ns/1ps
`default_nettype none
module dfc_op_timer #(
  parameter int W = 24
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [W-1:0] load,
  input wire logic pause,
  output logic running,
  output logic done
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic next_running;
  logic next_done;

  always_comb begin
    next_count = count;
    next_running = running;
    next_done = 1'b0;
    if (start) begin
      next_count = (load == '0) ? {{(W-1){1'b0}}, 1'b1} : load;
      next_running = 1'b1;
    end else if (running && !pause) begin
      if (count == {{(W-1){1'b0}}, 1'b1}) begin
        next_running = 1'b0;
        next_done = 1'b1;
        next_count = '0;
      end else begin
        next_count = count - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      running <= next_running;
      done <= next_done;
    end
  end
endmodule : dfc_op_timer
`default_nettype wire

// ===== rtl/dfc_pkg.sv
// shared constants for the dual flash command interface
package dfc_pkg;
  localparam int NUM_MAIN = 16;
  localparam int NUM_BOOT = 4;
  localparam int MAIN_SECTOR_KB = 64;
  localparam int BOOT_SECTOR0_KB = 16;
  localparam int BOOT_SECTOR1_KB = 8;
  localparam int BOOT_SECTOR2_KB = 8;
  localparam int BOOT_SECTOR3_KB = 32;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int CMD_ADDR_W = 12;
  localparam logic [11:0] UNLOCK_ADDR_A = 12'hAAA;
  localparam logic [11:0] UNLOCK_ADDR_B = 12'h554;
  localparam logic [7:0] ID_READ_OFS = 8'h02;
  localparam logic [7:0] PROT_READ_OFS = 8'h04;
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_BULK_ERASE = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_BYPASS_EXIT = 8'h00;
  localparam int CLK_MHZ = 20;
  localparam int PROG_TIME_US = 10;
  localparam int ADD_WINDOW_US = 80;
  localparam int ERASE_TIME_US = 1000;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int ADD_WINDOW_CYCLES = ADD_WINDOW_US * CLK_MHZ;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int TIMER_W = 24;
  localparam logic [15:0] FLASH_ID_DEFAULT = 16'h00C3;
endpackage : dfc_pkg

// ===== sim/dfc_host_bfm.sv
// host bus master and sector decode model facing the command sequencer
`timescale 1ns/1ps
`default_nettype none
module dfc_host_bfm
  import dfc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic boot_map,
  input wire logic [DATA_W-1:0] bus_rdata,
  output logic bus_wr,
  output logic bus_rd,
  output logic [ADDR_W-1:0] bus_addr,
  output logic [DATA_W-1:0] bus_wdata,
  output logic [NUM_MAIN-1:0] main_sector_select,
  output logic [NUM_BOOT-1:0] boot_sector_select
);
  initial begin
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 16'h0000;
    bus_wdata = 16'h0000;
  end

  // one sector per 4K region; boot array swapped in when boot_map is set
  always_comb begin
    main_sector_select = 16'h0000;
    boot_sector_select = 4'h0;
    if (boot_map) boot_sector_select[bus_addr[13:12]] = 1'b1;
    else main_sector_select[bus_addr[15:12]] = 1'b1;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(negedge clk_sys);
    bus_addr = a;
    bus_wdata = v;
    bus_wr = 1'b1;
    @(negedge clk_sys);
    bus_wr = 1'b0;
    // released data lines must not keep the last value
    bus_wdata = ~v;
  endtask : wr

  // read data is registered: it stands only in the cycle after the strobe edge
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(negedge clk_sys);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge clk_sys);
    v = bus_rdata;
    bus_rd = 1'b0;
  endtask : rd
endmodule : dfc_host_bfm
`default_nettype wire

// ===== sim/dual_flash_command_interface_tb.sv
// self-checking bench for the dual flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module dual_flash_command_interface_tb;
  import dfc_pkg::*;
  localparam logic [15:0] EXP_ID = 16'h5A3C; // arbitrary value
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic boot_map = 1'b0;
  logic bus_wr, bus_rd, busy_status_pin, prog_strobe, erase_strobe, erase_suspended;
  logic [ADDR_W-1:0] bus_addr, pa, program_target_address;
  logic [DATA_W-1:0] bus_wdata, bus_rdata, program_word_value, pd, d;
  logic [DATA_W-1:0] array_rdata = 16'h0000;
  logic [NUM_MAIN-1:0] main_sector_select, erase_main_mask;
  logic [NUM_MAIN-1:0] main_protect = 16'h0000;
  logic [NUM_BOOT-1:0] boot_sector_select, erase_boot_mask;
  logic [NUM_BOOT-1:0] boot_protect = 4'h0;
  logic [3:0] s;
  logic tgl = 1'b0;
  int fail_count = 0;
  int n_compared = 0;
  int ps, es, k;

  always #25 clk_sys = ~clk_sys;

  dfc_host_bfm host (.clk_sys(clk_sys), .boot_map(boot_map), .bus_rdata(bus_rdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .main_sector_select(main_sector_select), .boot_sector_select(boot_sector_select));

  dfc_cmd_seq #(.ERASE_TIME_CYCLES(50), .FLASH_ID(EXP_ID)) u_dfc_cmd_seq (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .array_rdata(array_rdata),
    .main_sector_select(main_sector_select), .boot_sector_select(boot_sector_select),
    .main_protect(main_protect), .boot_protect(boot_protect), .bus_rdata(bus_rdata),
    .busy_status_pin(busy_status_pin), .prog_strobe(prog_strobe),
    .program_target_address(program_target_address),
    .program_word_value(program_word_value), .erase_strobe(erase_strobe),
    .erase_main_mask(erase_main_mask), .erase_boot_mask(erase_boot_mask),
    .erase_suspended(erase_suspended));

  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk16

  task automatic chk1(input string n, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // upper address nibble and data byte are noise the decoder must ignore
  task automatic cmd(input logic [11:0] a, input logic [7:0] c);
    host.wr({4'($urandom), a}, {8'($urandom), c});
  endtask : cmd

  task automatic unlock(input logic [7:0] c);
    cmd(UNLOCK_ADDR_A, CMD_UNLOCK1);
    cmd(UNLOCK_ADDR_B, CMD_UNLOCK2);
    cmd(UNLOCK_ADDR_A, c);
  endtask : unlock

  task automatic erase_pre();
    unlock(CMD_ERASE_SETUP);
    cmd(UNLOCK_ADDR_A, CMD_UNLOCK1);
    cmd(UNLOCK_ADDR_B, CMD_UNLOCK2);
  endtask : erase_pre

  // counts strobe pulses over the current and next n falling edges
  task automatic watch(input int n);
    ps = 0;
    es = 0;
    for (int i = 0; i <= n; i++) begin
      if (i > 0) @(negedge clk_sys);
      ps += int'(prog_strobe === 1'b1);
      es += int'(erase_strobe === 1'b1);
    end
  endtask : watch

  task automatic wait_ready(input int lim);
    k = 0;
    while (busy_status_pin !== 1'b1 && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
    chk1("ready", 1'b1, busy_status_pin);
  endtask : wait_ready

  task automatic prog_one(input logic [3:0] sec, input logic exp);
    pa = {sec, 11'($urandom), 1'b0};
    pd = 16'($urandom);
    host.wr(pa, pd);
    watch(3);
    chk1("prog_strobe", exp, 1'(ps == 1));
    if (exp) begin
      chk16("prog_addr", pa, program_target_address);
      chk16("prog_word", pd, program_word_value);
      chk1("busy_prog", 1'b0, busy_status_pin);
      host.rd(pa, d);
      chk16("prog_status", {8'h00, ~pd[7], tgl, 6'h00}, d);
      tgl = ~tgl;
      wait_ready(400);
    end
  endtask : prog_one

  initial begin
    void'($urandom(31));
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    chk1("busy_reset", 1'b1, busy_status_pin);
    main_protect = {8'hFF, 4'h0, 4'($urandom)};
    for (int i = 0; i < 4; i++) begin
      array_rdata = 16'($urandom);
      host.rd(16'($urandom), d);
      chk16("plain_read", array_rdata, d);
      host.wr(16'($urandom), 16'($urandom));
      watch(3);
      chk1("plain_write", 1'b1, 1'(ps == 0));
    end
    unlock(CMD_ID);
    host.rd({8'($urandom), ID_READ_OFS}, d);
    chk16("flash_id", EXP_ID, d);
    boot_protect = 4'($urandom);
    for (int i = 0; i < 6; i++) begin
      boot_map = i[0];
      s = 4'($urandom);
      host.rd({s, 4'($urandom), PROT_READ_OFS}, d);
      chk16("prot_read", {15'h0, i[0] ? boot_protect[s[1:0]] : main_protect[s]}, d);
    end
    boot_map = 1'b0;
    cmd(UNLOCK_ADDR_A, CMD_PROGRAM);
    host.rd({8'($urandom), ID_READ_OFS}, d);
    chk16("id_held", EXP_ID, d);
    cmd(12'($urandom), CMD_RESET);
    array_rdata = 16'($urandom);
    host.rd({8'($urandom), ID_READ_OFS}, d);
    chk16("read_after_reset", array_rdata, d);
    for (int i = 0; i < 4; i++) begin
      s = i[0] ? 4'(8 + $urandom % 8) : 4'(4 + $urandom % 4);
      unlock(CMD_PROGRAM);
      prog_one(s, ~main_protect[s]);
    end
    cmd(UNLOCK_ADDR_A, CMD_UNLOCK1);
    cmd(UNLOCK_ADDR_B, 8'h12);
    cmd(UNLOCK_ADDR_A, CMD_PROGRAM);
    prog_one(4'd5, 1'b0);
    erase_pre();
    host.wr({4'd5, 12'($urandom)}, {8'($urandom), CMD_SECTOR_ERASE});
    watch(2);
    chk1("busy_erase", 1'b0, busy_status_pin);
    chk16("erase_mask1", 16'h0020, erase_main_mask);
    // sector 6 added and protected sector 9 refused at once, well inside the collect window
    host.wr({4'd6, 12'($urandom)}, {8'($urandom), CMD_SECTOR_ERASE});
    host.wr({4'd9, 12'($urandom)}, {8'($urandom), CMD_SECTOR_ERASE});
    watch(2);
    chk16("erase_mask2", 16'h0060, erase_main_mask);
    k = 0;
    while (erase_strobe !== 1'b1 && k < 2000) begin
      @(negedge clk_sys);
      k++;
    end
    chk1("erase_start", 1'b1, erase_strobe);
    cmd(12'($urandom), CMD_SUSPEND);
    watch(1);
    chk1("suspended", 1'b1, erase_suspended);
    array_rdata = 16'($urandom);
    host.rd({4'd2, 12'($urandom)}, d);
    chk16("read_in_suspend", array_rdata, d);
    cmd(12'($urandom), CMD_RESUME);
    watch(1);
    chk1("resumed", 1'b0, erase_suspended);
    chk1("busy_resumed", 1'b0, busy_status_pin);
    wait_ready(200);
    chk16("mask_clear", 16'h0000, erase_main_mask);
    boot_map = 1'b1;
    boot_protect = 4'($urandom) & 4'h7;
    erase_pre();
    cmd(UNLOCK_ADDR_A, CMD_BULK_ERASE);
    watch(4);
    chk1("bulk_start", 1'b1, 1'(es == 1));
    chk16("bulk_mask", {12'h000, ~boot_protect}, {12'h000, erase_boot_mask});
    wait_ready(200);
    boot_map = 1'b0;
    unlock(CMD_BYPASS);
    for (int i = 0; i < 2; i++) begin
      cmd(12'($urandom), CMD_PROGRAM);
      prog_one(4'(4 + $urandom % 4), 1'b1);
    end
    cmd(12'($urandom), CMD_ID);
    cmd(12'($urandom), CMD_BYPASS_EXIT);
    cmd(12'($urandom), CMD_PROGRAM);
    prog_one(4'd7, 1'b0);
    summarize();
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    fail_count++;
    summarize();
  end
endmodule : dual_flash_command_interface_tb
`default_nettype wire
